// ---- hdl/bbs_host.sv ----
// host controller driving a battery-backed asynchronous byte sram
// Function
// RULE_01: read when strobe high, select low
// RULE_02: data valid 70 ns after address/select
// RULE_03: device drives only with select and drive low
// RULE_04: old data held 10 ns after address change
// RULE_05: device floats within 25 ns of release
// RULE_06: device outputs change no sooner than 5 ns
// RULE_07: accesses spaced at least 70 ns apart
// RULE_08: write while strobe and select both low
// RULE_09: address stable whole write, 60 ns before end
// RULE_10: strobe low 50 ns, select low 55 ns
// RULE_11: data setup 30 ns, hold 5 ns
// RULE_12: strobe or select high before next access
// RULE_13: device floats 25 ns after strobe falls
// RULE_14: keep drive enable high during writes
// RULE_15: writes blocked while supply out of tolerance
// RULE_16: below switchover device ignores all pins
// RULE_17: inputs ignored up to 200 ms after power-up
// RULE_18: select high means no access, pins float
`timescale 1ns/1ns
`default_nettype none
module bbs_host #(
  parameter int RECOVERY_CYC = bbs_pkg::RECOVERY_CYC // power-up wait in cycles
) (
  input  wire logic                        core_clk,    // 125 MHz clock
  input  wire logic                        reset_n,     // async reset, active low
  input  wire logic                        power_ok,    // supply good, from a pin
  input  wire logic                        req_valid,   // access request
  input  wire logic                        req_write,   // 1 write, 0 read
  input  wire logic [bbs_pkg::ADDR_W-1:0]  req_addr,    // byte address
  input  wire logic [bbs_pkg::DATA_W-1:0]  req_wdata,   // write data
  output var  logic                        req_ready,   // request taken when high
  output var  logic                        resp_valid,  // access finished pulse
  output var  logic [bbs_pkg::DATA_W-1:0]  resp_rdata,  // read data
  output var  logic                        link_ready,  // device usable
  output var  logic                        sram_ce_n,   // chip select, active low
  output var  logic                        sram_oe_n,   // output drive, active low
  output var  logic                        sram_we_n,   // write strobe, active low
  output var  logic [bbs_pkg::ADDR_W-1:0]  byte_index,  // address pins
  input  wire logic [bbs_pkg::DATA_W-1:0]  data_bus_i,  // data pins in
  output var  logic [bbs_pkg::DATA_W-1:0]  data_bus_o,  // data pins out
  output var  logic                        data_bus_oe  // data pins driven
);
  typedef struct packed {
    bbs_pkg::bbs_state_t          state;
    logic                         pwr_s1;
    logic                         pwr_s2;
    logic [bbs_pkg::DATA_W-1:0]   din_s1;
    logic [bbs_pkg::DATA_W-1:0]   din_s2;
    logic                         req_ready;
    logic                         resp_valid;
    logic [bbs_pkg::DATA_W-1:0]   rdata;
    logic                         link_ready;
    logic                         ce_n;
    logic                         oe_n;
    logic                         we_n;
    logic [bbs_pkg::ADDR_W-1:0]   addr;
    logic [bbs_pkg::DATA_W-1:0]   data_o;
    logic                         data_oe;
  } bbs_hstate_t;

  localparam logic [bbs_pkg::TMR_W-1:0] REC_LD   = bbs_pkg::TMR_W'(RECOVERY_CYC - 1);
  localparam logic [bbs_pkg::TMR_W-1:0] RD_LD    = bbs_pkg::TMR_W'(bbs_pkg::RD_CYC - 1);
  localparam logic [bbs_pkg::TMR_W-1:0] WR_LD    = bbs_pkg::TMR_W'(bbs_pkg::WR_CYC - 1);
  localparam logic [bbs_pkg::TMR_W-1:0] FLOAT_LD = bbs_pkg::TMR_W'(bbs_pkg::FLOAT_CYC - 1);
  localparam logic [bbs_pkg::TMR_W-1:0] HOLD_LD  = bbs_pkg::TMR_W'(bbs_pkg::HOLD_CYC - 1);

  bbs_hstate_t               r_r;
  bbs_hstate_t               r_nxt;
  logic                      rst_q1_r;
  logic                      rst_q2_r;
  logic                      ld;
  logic [bbs_pkg::TMR_W-1:0] ld_val;

  bbs_tmr_if tmr_if ();

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q1_r <= 1'b0;
      rst_q2_r <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_q2_r <= rst_q1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase timer
  assign tmr_if.load     = ld;
  assign tmr_if.load_val = ld_val;

  bbs_timer u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_q2_r),
    .tmr      (tmr_if.tmr)
  );

  ////////////////////////////////////////////////////////////////////////
  // next-state logic for pins, handshake and synchronisers
  always_comb begin
    r_nxt            = r_r;
    ld               = 1'b0;
    ld_val           = '0;
    r_nxt.pwr_s1     = power_ok;
    r_nxt.pwr_s2     = r_r.pwr_s1;
    r_nxt.din_s1     = data_bus_i;
    r_nxt.din_s2     = r_r.din_s1;
    r_nxt.resp_valid = 1'b0;
    case (r_r.state)
      bbs_pkg::ST_OFF: begin
        ld     = 1'b1;
        ld_val = REC_LD;
        if (r_r.pwr_s2) begin
          r_nxt.state = bbs_pkg::ST_RECOV;
        end
      end
      bbs_pkg::ST_RECOV: begin
        if (tmr_if.done) begin // RULE_17
          r_nxt.state      = bbs_pkg::ST_IDLE;
          r_nxt.req_ready  = 1'b1;
          r_nxt.link_ready = 1'b1;
        end
      end
      bbs_pkg::ST_IDLE: begin
        if (req_valid) begin
          r_nxt.req_ready = 1'b0;
          r_nxt.addr      = req_addr; // RULE_09
          r_nxt.ce_n      = 1'b0;
          ld              = 1'b1;
          if (req_write) begin
            // strobe, select and data start together; drive enable stays high
            r_nxt.state   = bbs_pkg::ST_WR; // RULE_08
            r_nxt.we_n    = 1'b0; // RULE_14
            r_nxt.data_o  = req_wdata;
            r_nxt.data_oe = 1'b1;
            ld_val        = WR_LD;
          end else begin
            r_nxt.state = bbs_pkg::ST_RD; // RULE_01
            r_nxt.oe_n  = 1'b0; // RULE_03
            ld_val      = RD_LD;
          end
        end
      end
      bbs_pkg::ST_RD: begin
        if (tmr_if.done) begin // RULE_02
          r_nxt.ce_n       = 1'b1;
          r_nxt.oe_n       = 1'b1;
          r_nxt.rdata      = r_r.din_s2;
          r_nxt.resp_valid = 1'b1;
          r_nxt.state      = bbs_pkg::ST_FLOAT;
          ld               = 1'b1;
          ld_val           = FLOAT_LD;
        end
      end
      bbs_pkg::ST_FLOAT: begin
        // device may still drive the pins; do not start a write yet
        if (tmr_if.done) begin // RULE_05
          r_nxt.state     = bbs_pkg::ST_IDLE;
          r_nxt.req_ready = 1'b1;
        end
      end
      bbs_pkg::ST_WR: begin
        if (tmr_if.done) begin // RULE_10
          r_nxt.we_n  = 1'b1; // RULE_12
          r_nxt.ce_n  = 1'b1;
          r_nxt.state = bbs_pkg::ST_HOLD;
          ld          = 1'b1;
          ld_val      = HOLD_LD;
        end
      end
      bbs_pkg::ST_HOLD: begin
        if (tmr_if.done) begin // RULE_11
          r_nxt.data_oe    = 1'b0;
          r_nxt.resp_valid = 1'b1;
          r_nxt.state      = bbs_pkg::ST_IDLE; // RULE_07
          r_nxt.req_ready  = 1'b1;
        end
      end
      default: begin
        r_nxt.state = bbs_pkg::ST_OFF;
      end
    endcase
    // supply lost: the device ignores everything, so stop and wait for recovery
    if (!r_r.pwr_s2) begin // RULE_16
      r_nxt.state      = bbs_pkg::ST_OFF;
      r_nxt.ce_n       = 1'b1; // RULE_18
      r_nxt.oe_n       = 1'b1;
      r_nxt.we_n       = 1'b1; // RULE_15
      r_nxt.data_oe    = 1'b0;
      r_nxt.req_ready  = 1'b0;
      r_nxt.link_ready = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      r_r       <= '0;
      r_r.state <= bbs_pkg::ST_OFF;
      r_r.ce_n  <= 1'b1;
      r_r.oe_n  <= 1'b1;
      r_r.we_n  <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from the state register
  assign req_ready   = r_r.req_ready;
  assign resp_valid  = r_r.resp_valid;
  assign resp_rdata  = r_r.rdata;
  assign link_ready  = r_r.link_ready;
  assign sram_ce_n   = r_r.ce_n;
  assign sram_oe_n   = r_r.oe_n;
  assign sram_we_n   = r_r.we_n;
  assign byte_index  = r_r.addr;
  assign data_bus_o  = r_r.data_o;
  assign data_bus_oe = r_r.data_oe;

  ////////////////////////////////////////////////////////////////////////
  // checks on the pin sequence
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_q2_r || !r_r.pwr_s2);

  sequence s_strobe_low8;
    (!sram_we_n && !sram_ce_n)[*8];
  endsequence

  sequence s_drive_low11;
    (!sram_oe_n)[*8] ##1 (!sram_oe_n)[*3];
  endsequence

  a_strobe_width: assert property ( // RULE_10
    $fell(sram_we_n) |-> s_strobe_low8 ##1 (sram_we_n && sram_ce_n))
    else $error("write strobe width wrong");

  a_oe_in_write: assert property ( // RULE_14
    !sram_we_n |-> sram_oe_n)
    else $error("drive enable low during write");

  a_addr_stable: assert property ( // RULE_09
    (!sram_we_n && $past(!sram_we_n)) |-> $stable(byte_index))
    else $error("address moved during write");

  // the strobe rise is seen one edge late, so the hold is checked at that same edge
  a_data_setup: assert property ( // RULE_11
    $rose(sram_we_n) |-> data_bus_oe && $past(data_bus_oe, 4) && $stable(data_bus_o))
    else $error("write data setup or hold short");

  a_cycle_space: assert property ( // RULE_07
    $fell(sram_ce_n) |=> (!$fell(sram_ce_n))[*8])
    else $error("accesses closer than cycle time");

  a_read_wait: assert property ( // RULE_02
    $fell(sram_oe_n) |-> s_drive_low11 ##1 (sram_oe_n && resp_valid))
    else $error("read sampled too early");

  a_float_gap: assert property ( // RULE_05
    $rose(sram_oe_n) |-> (!data_bus_oe)[*4])
    else $error("host drove before device floated");

  a_no_fight: assert property ( // RULE_03
    data_bus_oe |-> sram_oe_n)
    else $error("both ends driving data pins");

  a_boot_quiet: assert property ( // RULE_17
    !link_ready |-> (sram_ce_n && !req_ready))
    else $error("access before recovery");
endmodule : bbs_host
`default_nettype wire

// ---- hdl/bbs_timer.sv ----
// down counter that times each phase of the sram cycle
`timescale 1ns/1ns
`default_nettype none
module bbs_timer (
  input  wire logic core_clk, // system clock
  input  wire logic rst_n,    // synchronised reset, active low
  bbs_tmr_if.tmr    tmr       // load and done
);
  typedef struct packed {
    logic [bbs_pkg::TMR_W-1:0] cnt;
  } bbs_tstate_t;

  bbs_tstate_t r_r;
  bbs_tstate_t r_nxt;

  ////////////////////////////////////////////////////////////////////////
  // count down to zero and stop; a load restarts the interval
  always_comb begin
    r_nxt = r_r;
    if (tmr.load) begin
      r_nxt.cnt = tmr.load_val;
    end else if (r_r.cnt != '0) begin
      r_nxt.cnt = r_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign tmr.done = (r_r.cnt == '0);
endmodule : bbs_timer
`default_nettype wire

// ---- pkg/bbs_pkg.sv ----
// constants and types shared by the battery-backed sram host port
`default_nettype none
package bbs_pkg;
  localparam int ADDR_W = 13;  // byte_index width, 8,192 bytes
  localparam int DATA_W = 8;   // data_bus width
  localparam int TMR_W  = 25;  // wide enough for the recovery count

  // clock and device timing in their own units
  localparam int CLK_NS        = 8;
  localparam int ADDR_ACC_NS   = 70;   // address_access_time
  localparam int FLOAT_NS      = 25;   // release to high impedance
  localparam int WE_PULSE_NS   = 50;   // strobe low width
  localparam int ADDR_END_NS   = 60;   // address valid to strobe high
  localparam int SETUP_NS      = 30;   // data_setup_time
  localparam int HOLD_NS       = 5;    // data_hold_time
  localparam int CYCLE_NS      = 70;   // read and write cycle time
  localparam int RECOVERY_MS   = 200;  // longest power-up recovery
  localparam int SYNC_STAGES   = 2;    // data_bus input synchroniser

  // least times round up to whole cycles
  localparam int ACC_CYC   = (ADDR_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int WEP_CYC   = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int AEND_CYC  = (ADDR_END_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC  = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYCLE_CYC = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC    = ACC_CYC + SYNC_STAGES;
  localparam int WR_CYC    = (WEP_CYC > AEND_CYC) ?
                             ((WEP_CYC > SETUP_CYC) ? WEP_CYC : SETUP_CYC) :
                             ((AEND_CYC > SETUP_CYC) ? AEND_CYC : SETUP_CYC);
  localparam int RECOVERY_CYC = int'((64'(RECOVERY_MS) * 64'd1000000) / 64'(CLK_NS));

  // controller states
  typedef enum logic [2:0] {
    ST_OFF   = 3'h0,
    ST_RECOV = 3'h1,
    ST_IDLE  = 3'h2,
    ST_RD    = 3'h3,
    ST_FLOAT = 3'h4,
    ST_WR    = 3'h5,
    ST_HOLD  = 3'h6
  } bbs_state_t;
endpackage : bbs_pkg
`default_nettype wire

// ---- pkg/bbs_tmr_if.sv ----
// interval timer hookup between the controller and its timer
`timescale 1ns/1ns
`default_nettype none
interface bbs_tmr_if;
  logic                     load;      // load a new interval
  logic [bbs_pkg::TMR_W-1:0] load_val; // interval length minus one
  logic                     done;      // interval has run out
  modport ctrl (output load, output load_val, input done);
  modport tmr  (input load, input load_val, output done);
endinterface : bbs_tmr_if
`default_nettype wire

// ---- tb/bbs_sram_model.sv ----
// behavioural battery-backed byte sram seen by the host port
`timescale 1ns/1ns
`default_nettype none
module bbs_sram_model #(
  parameter int REC_NS = 100 // power-up recovery, shortened
) (
  input  wire logic                       power_ok,   // supply in tolerance
  input  wire logic                       ce_n,       // chip select, active low
  input  wire logic                       oe_n,       // output drive, active low
  input  wire logic                       we_n,       // write strobe, active low
  input  wire logic [bbs_pkg::ADDR_W-1:0] byte_index, // address pins
  input  wire logic [bbs_pkg::DATA_W-1:0] data_in,    // resolved data pins
  output var  logic [bbs_pkg::DATA_W-1:0] dq_o,       // data the device drives
  output var  logic                       dq_oe       // device drives the pins
);
  logic [7:0] mem [0:8191];
  int         acc_ns  = 70;           // address and select access
  int         oacc_ns = 35;           // drive access
  time        t_a = 0, t_e = 0, t_g = 0, t_p = 0, rdy = 0;
  wire logic  wr_on = !we_n && !ce_n; // write window
  ////////////////////////////////////////////////////////////////////////
  // inputs count only with good supply after the recovery interval
  function automatic logic live();
    return power_ok && ($time >= t_p + REC_NS);
  endfunction : live
  always @(posedge power_ok) t_p = $time;
  always @(byte_index) t_a = $time;
  always @(negedge ce_n) t_e = $time;
  always @(negedge oe_n) t_g = $time;
  // pins driven only while selected and reading
  always @(ce_n, oe_n, we_n, power_ok) begin
    if (!ce_n && !oe_n && we_n && live()) dq_oe <= #5 1'b1;
    else dq_oe <= #20 1'b0;
  end
  // old byte held after an address change, junk until the access is done
  always #1 begin
    rdy = t_a + acc_ns;
    if (t_e + acc_ns > rdy) rdy = t_e + acc_ns;
    if (t_g + oacc_ns > rdy) rdy = t_g + oacc_ns;
    if ($time >= t_a + 10) begin
      if ($time >= rdy) dq_o = mem[byte_index];
      else dq_o = ~dq_o;
    end
  end
  // a write lands at the earlier rising edge of strobe or select
  always @(negedge wr_on) if (live()) mem[byte_index] = data_in;
endmodule : bbs_sram_model
`default_nettype wire

// ---- tb/tb_bbs_host.sv ----
// self-checking bench for the sram host port
`timescale 1ns/1ns
`default_nettype none
module tb_bbs_host;
  logic                       core_clk, reset_n, power_ok, req_valid, req_write;
  logic [bbs_pkg::ADDR_W-1:0] req_addr, byte_index;
  logic [bbs_pkg::DATA_W-1:0] req_wdata, resp_rdata, data_bus_o, dbus, dq_o;
  logic [bbs_pkg::DATA_W-1:0] junk = 8'h5a;
  logic                       req_ready, resp_valid, link_ready, dq_oe, data_bus_oe;
  logic                       sram_ce_n, sram_oe_n, sram_we_n;
  int                         error_cnt = 0, check_count = 0, seed, i, r0, resp_cnt = 0;
  time                        t_cf = 0, t_wf = 0, t_ad = 0, t_dd = 0, t_wr = 0;
  logic [7:0]                 exp_mem [int];
  logic [12:0]                aq [$];
  bbs_host #(.RECOVERY_CYC(20)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .power_ok(power_ok), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata), .link_ready(link_ready),
    .sram_ce_n(sram_ce_n), .sram_oe_n(sram_oe_n), .sram_we_n(sram_we_n),
    .byte_index(byte_index), .data_bus_i(dbus), .data_bus_o(data_bus_o),
    .data_bus_oe(data_bus_oe));
  bbs_sram_model mdl (.power_ok(power_ok), .ce_n(sram_ce_n), .oe_n(sram_oe_n),
    .we_n(sram_we_n), .byte_index(byte_index), .data_in(dbus), .dq_o(dq_o),
    .dq_oe(dq_oe));
  ////////////////////////////////////////////////////////////////////////
  // undriven pins wander, so a stale value never passes for data
  always @(posedge core_clk) junk <= junk + 8'h3d;
  assign dbus = data_bus_oe ? data_bus_o : ((dq_oe === 1'b1) ? dq_o : junk);
  always @(posedge core_clk) if (resp_valid === 1'b1) resp_cnt++;
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // compare tasks and verdict
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte
  task automatic chk_flag(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_flag
  task automatic test_done();
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // wait for the port to open after power-up recovery
  task automatic wait_link();
    int n;
    n = 0;
    while (link_ready !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    chk_flag("link_up", 1'b1, link_ready & req_ready & (n >= 20));
  endtask : wait_link
  // one byte access, held until taken, then its latency and any read byte checked against the expected copy
  task automatic access(input logic w, input logic [12:0] a, input logic [7:0] d);
    int n;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    req_valid = 1'b0;
    n = 1;
    while (resp_valid !== 1'b1 && n < 30) begin
      @(negedge core_clk);
      n++;
    end
    if (w) begin
      chk_flag("write_latency", 1'b1, n == 10);
      exp_mem[a] = d;
    end else begin
      chk_flag("read_latency", 1'b1, n <= 13);
      chk_byte("read_data", exp_mem[a], resp_rdata);
    end
  endtask : access
  ////////////////////////////////////////////////////////////////////////
  // pin timing seen from the device side
  always @(byte_index) t_ad = $time;
  always @(data_bus_o) t_dd = $time;
  always @(negedge sram_we_n) t_wf = $time;
  always @(negedge sram_ce_n) begin
    if (t_cf > 0 && power_ok) chk_flag("cycle_gap", 1'b1, $time - t_cf >= 70);
    t_cf = $time;
  end
  always @(posedge sram_we_n) if (reset_n && power_ok && t_wf > 0) begin
    t_wr = $time;
    chk_flag("strobe_width", 1'b1, t_wr - t_wf >= 50);
    chk_flag("addr_setup", 1'b1, t_ad <= t_wf && t_wr - t_ad >= 60);
    chk_flag("data_setup", 1'b1, data_bus_oe && t_wr - t_dd >= 30);
    chk_flag("drive_high", 1'b1, sram_oe_n);
    #5;
    // select moves in the same step as the strobe, so it is looked at once both settled
    chk_flag("select_width", 1'b1, (t_wr - t_cf >= 55) && sram_ce_n);
    chk_flag("data_hold", 1'b1,
             data_bus_oe && $time - t_dd >= 35 && $time - t_ad >= 65);
  end
  always @(posedge core_clk) if (reset_n) chk_flag("contention", 1'b0, data_bus_oe & dq_oe);
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 78549;
    reset_n = 1'b0;
    power_ok = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 13'h0000;
    req_wdata = 8'h00;
    repeat (3) @(negedge core_clk);
    chk_flag("reset_pins", 1'b1, sram_ce_n & ~link_ready);
    reset_n = 1'b1;
    wait_link();
    // corner and random addresses written, read back in reverse, slow and fast
    aq = '{13'h0000, 13'h1fff};
    for (i = 0; i < 10; i++) aq.push_back(13'($random(seed)));
    for (i = 0; i < 12; i++) access(1'b1, aq[i], 8'($random(seed)));
    for (i = 11; i >= 0; i--) begin
      mdl.acc_ns = (i % 2) ? 70 : 30;
      mdl.oacc_ns = (i % 2) ? 35 : 15;
      access(1'b0, aq[i], 8'h00);
    end
    for (i = 0; i < 20; i++) access(i % 3 != 0, aq[i % 12], 8'($random(seed)));
    // supply lost in mid write: no answer, pins idle, nothing stored
    while (req_ready !== 1'b1) @(negedge core_clk);
    req_valid = 1'b1;
    req_write = 1'b1;
    req_addr = aq[0];
    req_wdata = ~exp_mem[aq[0]];
    @(negedge core_clk);
    req_valid = 1'b0;
    r0 = resp_cnt;
    chk_flag("abort_start", 1'b0, sram_we_n);
    repeat (2) @(negedge core_clk);
    power_ok = 1'b0;
    repeat (12) @(negedge core_clk);
    chk_flag("power_ready", 1'b0, link_ready | req_ready | (resp_cnt != r0));
    chk_flag("power_pins", 1'b1, sram_ce_n & sram_we_n & ~data_bus_oe);
    power_ok = 1'b1;
    wait_link();
    access(1'b0, aq[0], 8'h00);
    test_done();
  end
  // watchdog against a hung handshake
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
endmodule : tb_bbs_host
`default_nettype wire
